// ### rsc_pkg.sv
// Purpose: constants for the reset source control block
// Assumes: one 125 MHz clock, AXI4-Lite register access
// Notes: offsets and times are held here and nowhere else
package rsc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int LV_FILTER_NS = 1000;
  localparam int CODE_FAULT_DELAY_NS = 2000;
  localparam int LV_FILTER_CYC = (LV_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CODE_FAULT_CYC = (CODE_FAULT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_BROWNOUT_LEVEL = 8'h00;
  localparam logic [7:0] OFF_RESET_CAUSE = 8'h04;
  localparam logic [7:0] OFF_WATCHDOG_CTRL = 8'h08;
  localparam logic [7:0] OFF_CORE_STATUS = 8'h0C;
  localparam logic [7:0] OFF_CORE_STATE = 8'h10;
  localparam logic [7:0] OFF_PORT_STATE = 8'h14;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LVL_ENABLE_21V = 8'h5A;
  localparam logic [7:0] LVL_DISABLE = 8'hA5;
  localparam logic [7:0] LVL_POR = 8'h5A;
  localparam logic [7:0] WDT_CTRL_POR = 8'h57;
  localparam logic [7:0] PCL_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [5:0] PORT_ONES = 6'h3F;
  localparam logic [4:0] WDT_EN_CODE = 5'h0A;
  localparam logic [4:0] WDT_DIS_CODE = 5'h15;

  // reset-cause bit positions
  localparam int CAUSE_WDT_BIT = 0;
  localparam int CAUSE_CODE_BIT = 1;
  localparam int CAUSE_LV_BIT = 2;
  // status bit positions
  localparam int STAT_PDF_BIT = 0;
  localparam int STAT_TO_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_FAULT_WAIT = 3'b010,
    ST_RESET = 3'b100
  } seq_state_e;

endpackage

// ### rsc_delay_counter.sv
// Purpose: counts how long a condition has held
// Assumes: condition is synchronous to CLK
// Notes: done stays high while the condition holds past the limit
`timescale 1ns/1ps
module rsc_delay_counter
  import rsc_pkg::*;
#(
  parameter int LIMIT = 4
) (
  input wire logic CLK, // system clock
  input wire logic RST_N, // async reset, active low
  input wire logic cond, // condition being timed
  output logic done // condition held LIMIT cycles
);
  logic [CNT_W-1:0] count_reg;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      count_reg <= '0;
    end else if (!cond) begin
      count_reg <= '0;
    end else if (count_reg != CNT_W'(LIMIT)) begin
      count_reg <= count_reg + CNT_W'(1);
    end
  end

  assign done = cond && (count_reg == CNT_W'(LIMIT));
endmodule

// ### rsc_axil_slave.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: 32-bit data, word aligned registers
// Notes: write strobe pulses one cycle once address and data are both held
`timescale 1ns/1ps
module rsc_axil_slave
  import rsc_pkg::*;
(
  input wire logic CLK, // system clock
  input wire logic RST_N, // async reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read valid
  input wire logic rready, // read ready
  output logic wr_en, // one-cycle write strobe
  output logic [7:0] wr_addr, // held write address
  output logic [7:0] wr_data, // held write byte 0
  output logic rd_en, // one-cycle read strobe
  output logic [7:0] rd_addr, // read address
  input wire logic [7:0] rd_val, // register value for rd_addr
  input wire logic rd_hit, // rd_addr is mapped
  input wire logic wr_hit // wr_addr is mapped
);
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] strb_reg;

  assign awready = !aw_held_reg && !bvalid;
  assign wready = !w_held_reg && !bvalid;
  assign wr_en = aw_held_reg && w_held_reg && !bvalid;
  assign arready = !rvalid;
  assign rd_en = arvalid && arready;
  assign rd_addr = araddr;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      strb_reg <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wr_data <= wdata[7:0];
        strb_reg <= wstrb;
      end
      if (wr_en) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rd_en) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_val};
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// ### reset_source_control.sv
// Purpose: reset source control: brown-out code guard, reset causes, core reset state
// Assumes: single clock; RST_N is the power-on reset; supply and watchdog events synchronous
// Notes: registers over AXI4-Lite; byte 0 of each word carries the register
// Notes on behaviour
// - code 5A enables low-voltage reset at 2.1V, code A5 disables it.
// - any other brown-out code resets the system after the code-fault delay.
// - a code-fault reset restores the brown-out code to 5A.
// - low supply resets only after persisting past the filter time.
// - a low-supply reset keeps the brown-out code unchanged.
// - low-supply reset sets cause bit 2; only software clears it.
// - undefined brown-out code sets cause bit 1; only software clears it.
// - cause bits 7 to 3 read as zero.
// - watchdog timeout in fast or slow mode sets the timeout flag.
// - sleep watchdog timeout clears only PC and SP, sets timeout flag.
// - power-on reset clears timeout and power-down flags.
// - low-voltage reset in run mode leaves both status flags unchanged.
// - sleep watchdog sets both flags; run watchdog sets timeout only.
// - power-on reset disables every interrupt.
// - power-on reset clears watchdog and time bases; watchdog restarts counting.
// - power-on reset switches off every timer module.
// - power-on and run watchdog reset load ones into port data and direction.
// - power-on reset points the stack pointer at the top of stack.
// - power-on and both watchdog resets load program counter low with zero.
// - power-on and run watchdog load watchdog control 57, brown-out 5A.
// - undefined watchdog enable code sets watchdog fault flag; software clears.
// - low-voltage reset is disabled in idle or sleep mode.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module reset_source_control
  import rsc_pkg::*;
(
  input wire logic CLK, // system clock 125 MHz
  input wire logic RST_N, // power-on reset, active low
  input wire logic [7:0] AWADDR, // axi write address
  input wire logic AWVALID, // axi write address valid
  output logic AWREADY, // axi write address ready
  input wire logic [31:0] WDATA, // axi write data
  input wire logic [3:0] WSTRB, // axi write strobes
  input wire logic WVALID, // axi write data valid
  output logic WREADY, // axi write data ready
  output logic [1:0] BRESP, // axi write response
  output logic BVALID, // axi write response valid
  input wire logic BREADY, // axi write response ready
  input wire logic [7:0] ARADDR, // axi read address
  input wire logic ARVALID, // axi read address valid
  output logic ARREADY, // axi read address ready
  output logic [31:0] RDATA, // axi read data
  output logic [1:0] RRESP, // axi read response
  output logic RVALID, // axi read valid
  input wire logic RREADY, // axi read ready
  input wire logic LOW_SUPPLY, // comparator: supply under threshold
  input wire logic WDT_TIMEOUT, // watchdog overflow pulse
  input wire logic SLEEP_MODE, // core in idle or sleep
  output logic LV_RESET_ENABLE, // low-voltage reset armed at 2.1V
  output logic SYS_RESET, // system reset; one cycle on code fault, held while lv_reset or a run watchdog timeout lasts
  output logic CORE_RESET, // full core reset, same as SYS_RESET
  output logic [7:0] PCL_VALUE, // program counter low
  output logic [7:0] SP_VALUE, // stack pointer
  output logic [5:0] PORT_DATA, // port data latches
  output logic [5:0] PORT_DIR, // port direction, 1 is input
  output logic IRQ_ENABLE, // global interrupt enable
  output logic TIMERS_ON, // timer modules run
  output logic WDT_CLEAR // clears watchdog counter and time bases
);
  logic wr_en;
  logic rd_en;
  logic rd_hit;
  logic wr_hit;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_val;
  logic [7:0] brownout_level_reg;
  logic [7:0] watchdog_control_reg;
  logic [2:0] reset_cause_reg;
  logic timeout_status_flag;
  logic power_down_flag;
  logic lv_done;
  logic fault_done;
  logic code_bad;
  logic wdt_bad;
  logic lv_reset;
  logic wdt_run;
  logic wdt_sleep;
  logic por_done_reg;
  seq_state_e state_reg;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFF_BROWNOUT_LEVEL) || (a == OFF_RESET_CAUSE) ||
      (a == OFF_WATCHDOG_CTRL) || (a == OFF_CORE_STATUS) ||
      (a == OFF_CORE_STATE) || (a == OFF_PORT_STATE);
  endfunction

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  rsc_axil_slave u_bus (
    .CLK(CLK),
    .RST_N(RST_N),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_val(rd_val),
    .rd_hit(rd_hit),
    .wr_hit(wr_hit)
  );

  assign rd_hit = is_mapped(rd_addr);
  assign wr_hit = is_mapped(wr_addr);

  always_comb begin
    unique case (rd_addr)
      OFF_BROWNOUT_LEVEL: rd_val = brownout_level_reg;
      OFF_RESET_CAUSE: rd_val = {5'b00000, reset_cause_reg};
      OFF_WATCHDOG_CTRL: rd_val = watchdog_control_reg;
      OFF_CORE_STATUS: rd_val = {6'b000000, timeout_status_flag, power_down_flag};
      OFF_CORE_STATE: rd_val = SP_VALUE;
      OFF_PORT_STATE: rd_val = {2'b00, PORT_DIR};
      default: rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // low-voltage reset is armed only by the enable code and only outside sleep
  assign LV_RESET_ENABLE = (brownout_level_reg == LVL_ENABLE_21V) && !SLEEP_MODE;
  assign code_bad = (brownout_level_reg != LVL_ENABLE_21V) &&
    (brownout_level_reg != LVL_DISABLE);
  assign wdt_bad = (watchdog_control_reg[7:3] != WDT_EN_CODE) &&
    (watchdog_control_reg[7:3] != WDT_DIS_CODE);

  rsc_delay_counter #(.LIMIT(LV_FILTER_CYC + 1)) u_lv_filter (
    .CLK(CLK),
    .RST_N(RST_N),
    .cond(LOW_SUPPLY && LV_RESET_ENABLE),
    .done(lv_done)
  );

  rsc_delay_counter #(.LIMIT(CODE_FAULT_CYC)) u_fault_delay (
    .CLK(CLK),
    .RST_N(RST_N),
    .cond(code_bad || wdt_bad),
    .done(fault_done)
  );

  assign lv_reset = lv_done;
  assign wdt_run = WDT_TIMEOUT && !SLEEP_MODE;
  assign wdt_sleep = WDT_TIMEOUT && SLEEP_MODE;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_RUN;
    end else begin
      unique case (state_reg)
        ST_RUN: state_reg <= (code_bad || wdt_bad) ? ST_FAULT_WAIT : ST_RUN;
        ST_FAULT_WAIT: begin
          if (fault_done) begin
            state_reg <= ST_RESET;
          end else if (!(code_bad || wdt_bad)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RESET: state_reg <= ST_RUN;
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  assign SYS_RESET = lv_reset || wdt_run || (state_reg == ST_RESET);
  assign CORE_RESET = SYS_RESET;

  // ----------------------------------------------------------------
  // brown-out level and watchdog control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      brownout_level_reg <= LVL_POR;
    end else if (wdt_run || (state_reg == ST_RESET && code_bad)) begin
      brownout_level_reg <= LVL_POR;
    end else if (wr_en && wr_addr == OFF_BROWNOUT_LEVEL) begin
      brownout_level_reg <= wr_data; // lv_reset leaves it alone
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      watchdog_control_reg <= WDT_CTRL_POR;
    end else if (wdt_run || (state_reg == ST_RESET && wdt_bad)) begin
      watchdog_control_reg <= WDT_CTRL_POR;
    end else if (wr_en && wr_addr == OFF_WATCHDOG_CTRL) begin
      watchdog_control_reg <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // reset-cause flags: hardware set beats software clear
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      reset_cause_reg <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_en && wr_addr == OFF_RESET_CAUSE && !wr_data[i]) begin
          reset_cause_reg[i] <= 1'b0;
        end
      end
      if (lv_reset) begin
        reset_cause_reg[CAUSE_LV_BIT] <= 1'b1;
      end
      if (code_bad) begin
        reset_cause_reg[CAUSE_CODE_BIT] <= 1'b1;
      end
      if (state_reg == ST_RESET && wdt_bad) begin
        reset_cause_reg[CAUSE_WDT_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      timeout_status_flag <= 1'b0;
      power_down_flag <= 1'b0;
    end else if (wdt_sleep) begin
      timeout_status_flag <= 1'b1;
      power_down_flag <= 1'b1;
    end else if (wdt_run) begin
      timeout_status_flag <= 1'b1;
    end
    // lv_reset touches neither flag
  end

  // ----------------------------------------------------------------
  // core state loaded by resets
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PCL_VALUE <= PCL_RESET;
      SP_VALUE <= SP_RESET;
    end else if (WDT_TIMEOUT || SYS_RESET) begin
      PCL_VALUE <= PCL_RESET;
      SP_VALUE <= SP_RESET;
    end else if (wr_en && wr_addr == OFF_CORE_STATE) begin
      // stand-in for the core moving on, so that a reset can be seen to act
      PCL_VALUE <= wr_data;
      SP_VALUE <= wr_data;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PORT_DATA <= PORT_ONES;
      PORT_DIR <= PORT_ONES;
    end else if (wdt_run) begin
      PORT_DATA <= PORT_ONES;
      PORT_DIR <= PORT_ONES;
    end else if (wr_en && wr_addr == OFF_PORT_STATE) begin
      PORT_DATA <= wr_data[5:0];
      PORT_DIR <= wr_data[5:0];
    end
  end

  // power-on one-shot: clear the watchdog once, then let it count
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      por_done_reg <= 1'b0;
      IRQ_ENABLE <= 1'b0;
      TIMERS_ON <= 1'b0;
    end else begin
      por_done_reg <= 1'b1;
      if (wr_en && wr_addr == OFF_CORE_STATUS) begin
        IRQ_ENABLE <= wr_data[2];
        TIMERS_ON <= wr_data[3];
      end
    end
  end

  assign WDT_CLEAR = !por_done_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_lv_enable;
    @(posedge CLK) disable iff (!RST_N)
    (brownout_level_reg == LVL_DISABLE) |-> !LV_RESET_ENABLE;
  endproperty
  a_lv_enable: assert property (p_lv_enable) else $error("low-voltage reset armed");

  property p_code_fault;
    @(posedge CLK) disable iff (!RST_N)
    (state_reg == ST_RESET && code_bad) |=> (brownout_level_reg == LVL_POR);
  endproperty
  a_code_fault: assert property (p_code_fault) else $error("level not restored");

  property p_lv_short;
    @(posedge CLK) disable iff (!RST_N)
    $rose(LOW_SUPPLY) |-> !lv_reset [*3];
  endproperty
  a_lv_short: assert property (p_lv_short) else $error("unfiltered low-voltage reset");

  property p_lv_flag;
    @(posedge CLK) disable iff (!RST_N)
    lv_reset |=> reset_cause_reg[CAUSE_LV_BIT];
  endproperty
  a_lv_flag: assert property (p_lv_flag) else $error("low-voltage cause not set");

  property p_code_flag;
    @(posedge CLK) disable iff (!RST_N)
    code_bad |=> reset_cause_reg[CAUSE_CODE_BIT];
  endproperty
  a_code_flag: assert property (p_code_flag) else $error("code fault cause not set");

  property p_sleep_wdt;
    @(posedge CLK) disable iff (!RST_N)
    wdt_sleep |=> timeout_status_flag && power_down_flag && SP_VALUE == SP_RESET
      && PCL_VALUE == PCL_RESET && $stable(PORT_DIR) && $stable(PORT_DATA);
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep timeout wrong");

  property p_run_wdt;
    @(posedge CLK) disable iff (!RST_N)
    wdt_run |=> timeout_status_flag && $stable(power_down_flag) && PORT_DIR == PORT_ONES
      && PORT_DATA == PORT_ONES;
  endproperty
  a_run_wdt: assert property (p_run_wdt) else $error("run timeout wrong");

  property p_lv_flags;
    @(posedge CLK) disable iff (!RST_N)
    (lv_reset && !WDT_TIMEOUT) |=> $stable(timeout_status_flag) && $stable(power_down_flag);
  endproperty
  a_lv_flags: assert property (p_lv_flags) else $error("status changed by lv reset");

  property p_sleep_lv;
    @(posedge CLK) disable iff (!RST_N)
    SLEEP_MODE |-> !lv_reset;
  endproperty
  a_sleep_lv: assert property (p_sleep_lv) else $error("lv reset in sleep");
endmodule

// ### reset_source_control_bench.sv
// Purpose: self-checking bench for reset_source_control over AXI4-Lite
// Assumes: 125 MHz clock, inputs driven by non-blocking assignment at the rising edge
// Notes: status is checked on bits 1:0 only, since other bits there are write controls
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module reset_source_control_bench
  import rsc_pkg::*;
;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, low_supply, wdt_timeout, sleep_mode;
  logic [7:0] awaddr, araddr, program_counter_low, sp;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, lv_en, sys_rst, core_rst, irq_en, tmr_on, wdt_clr;
  logic [1:0] bresp, rresp, r;
  logic [5:0] pdata, pdir;
  int fails = 0;
  int n_tests = 0;
  int sys_cnt = 0;
  int s;
  reset_source_control dut (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .LOW_SUPPLY(low_supply), .WDT_TIMEOUT(wdt_timeout), .SLEEP_MODE(sleep_mode),
    .LV_RESET_ENABLE(lv_en), .SYS_RESET(sys_rst), .CORE_RESET(core_rst), .PCL_VALUE(program_counter_low),
    .SP_VALUE(sp), .PORT_DATA(pdata), .PORT_DIR(pdir), .IRQ_ENABLE(irq_en),
    .TIMERS_ON(tmr_on), .WDT_CLEAR(wdt_clr));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (sys_rst === 1'b1) sys_cnt <= sys_cnt + 1;
  // ------------------------------------------------------------
  // bus and helper tasks
  // ------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    axw(a, v, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    axr(a, d, r);
    `CHK($sformatf("register %h", a), {24'h000000, e}, d)
  endtask
  task automatic stc(input logic [1:0] e);
    axr(OFF_CORE_STATUS, d, r);
    `CHK("status flags", e, d[1:0])
  endtask
  task automatic low(input int n);
    @(posedge clk);
    low_supply <= 1'b1;
    repeat (n) @(posedge clk);
    low_supply <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wdt_pulse;
    @(posedge clk);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_rst(input int lim);
    int n;
    for (n = 0; n < lim && sys_cnt == s; n++) @(posedge clk);
  endtask
  task automatic por_chk;
    `CHK("pc low", PCL_RESET, program_counter_low)
    `CHK("stack pointer", SP_RESET, sp)
    `CHK("port data", PORT_ONES, pdata)
    `CHK("port dir", PORT_ONES, pdir)
    `CHK("irq enable", 1'b0, irq_en)
    `CHK("timers on", 1'b0, tmr_on)
    stc(2'h0);
    rc(OFF_BROWNOUT_LEVEL, LVL_POR);
    rc(OFF_WATCHDOG_CTRL, WDT_CTRL_POR);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #160000;
    fails++;
    report_and_stop;
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, low_supply, wdt_timeout, sleep_mode} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (3) @(posedge clk);
    `CHK("wdt clear in reset", 1'b1, wdt_clr)
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("wdt clear", 1'b0, wdt_clr)
    por_chk;
    rc(OFF_RESET_CAUSE, 8'h00);
    axr(8'h40, d, r);
    `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {r, d})
    axw(8'h40, 8'hFF, r);
    `CHK("unmapped write", RESP_SLVERR, r)
    wr(OFF_BROWNOUT_LEVEL, LVL_DISABLE);
    `CHK("lv enable", 1'b0, lv_en)
    wr(OFF_BROWNOUT_LEVEL, LVL_ENABLE_21V);
    `CHK("lv enable", 1'b1, lv_en)
    sleep_mode <= 1'b1;
    s = sys_cnt;
    low(140);
    `CHK("lv enable asleep", 1'b0, lv_en)
    `CHK("reset asleep", 1'b1, sys_cnt == s)
    sleep_mode <= 1'b0;
    low(100);
    `CHK("short low supply", 1'b1, sys_cnt == s)
    rc(OFF_RESET_CAUSE, 8'h00);
    wr(OFF_CORE_STATUS, 8'h0C);
    wr(OFF_PORT_STATE, 8'h00);
    wr(OFF_CORE_STATE, 8'h3C);
    wr(OFF_WATCHDOG_CTRL, 8'h52);
    wr(OFF_BROWNOUT_LEVEL, LVL_DISABLE);
    wdt_pulse;
    `CHK("run wdt reset", 1'b1, sys_cnt != s)
    stc(2'h2);
    `CHK("port dir", PORT_ONES, pdir)
    `CHK("port data", PORT_ONES, pdata)
    `CHK("pc low", PCL_RESET, program_counter_low)
    rc(OFF_WATCHDOG_CTRL, WDT_CTRL_POR);
    rc(OFF_BROWNOUT_LEVEL, LVL_POR);
    wr(OFF_PORT_STATE, 8'h00);
    wr(OFF_CORE_STATE, 8'h3C);
    wr(OFF_WATCHDOG_CTRL, 8'h52);
    wr(OFF_BROWNOUT_LEVEL, LVL_DISABLE);
    sleep_mode <= 1'b1;
    wdt_pulse;
    sleep_mode <= 1'b0;
    stc(2'h3);
    `CHK("port dir kept", 6'h00, pdir)
    `CHK("port data kept", 6'h00, pdata)
    `CHK("sleep pc and sp", {PCL_RESET, SP_RESET}, {program_counter_low, sp})
    rc(OFF_WATCHDOG_CTRL, 8'h52);
    rc(OFF_BROWNOUT_LEVEL, LVL_DISABLE);
    wr(OFF_BROWNOUT_LEVEL, LVL_ENABLE_21V);
    s = sys_cnt;
    low(140);
    `CHK("lv reset", 1'b1, sys_cnt != s)
    rc(OFF_RESET_CAUSE, 8'h04);
    stc(2'h3);
    rc(OFF_BROWNOUT_LEVEL, LVL_ENABLE_21V);
    wr(OFF_RESET_CAUSE, 8'hFF);
    rc(OFF_RESET_CAUSE, 8'h04);
    wr(OFF_RESET_CAUSE, 8'h00);
    rc(OFF_RESET_CAUSE, 8'h00);
    wr(OFF_BROWNOUT_LEVEL, 8'h33);
    s = sys_cnt;
    rc(OFF_RESET_CAUSE, 8'h02);
    wr(OFF_RESET_CAUSE, 8'h00);
    rc(OFF_RESET_CAUSE, 8'h02);
    wait_rst(200);
    `CHK("early code reset", 1'b1, sys_cnt == s)
    wait_rst(200);
    `CHK("code reset", 1'b1, sys_cnt != s)
    rc(OFF_BROWNOUT_LEVEL, LVL_POR);
    wr(OFF_RESET_CAUSE, 8'h00);
    wr(OFF_WATCHDOG_CTRL, 8'h07);
    s = sys_cnt;
    wait_rst(400);
    `CHK("wdt code reset", 1'b1, sys_cnt != s)
    rc(OFF_RESET_CAUSE, 8'h01);
    wr(OFF_CORE_STATE, 8'h3C);
    wr(OFF_BROWNOUT_LEVEL, LVL_DISABLE);
    wr(OFF_WATCHDOG_CTRL, 8'h52);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("wdt clear in reset", 1'b1, wdt_clr)
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    por_chk;
    report_and_stop;
  end
endmodule
